/* File: hw/aes_host_ctrl.sv */
// Host controller that drives the cipher through its register ports
`timescale 1ns/100ps
module aes_host_ctrl #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Job request
  input wire logic job_valid,
  input wire aes_host_pkg::job_t job_in,
  output logic job_ready,
  // Input bytes: data, key, data, key ... then extra key bytes
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // Result bytes
  output logic res_valid,
  output logic [7:0] res_data,
  input wire logic res_ready,
  // Status
  output logic busy,
  output logic done,
  // Device register port
  output aes_host_pkg::sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic cipher_done_irq
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_CFG, ST_FEED, ST_POLL_RD, ST_POLL_WT, ST_RES_RD,
    ST_RES_WT, ST_RES_OUT, ST_DMA_WR, ST_DMA_RD, ST_DMA_WT, ST_DONE
  } state_t;

  state_t state_q;
  logic [5:0] step_q;
  aes_host_pkg::job_t job_q;
  logic cfg_ok_q;
  logic [7:0] cfg_b_q;
  logic [7:0] cfg_d_q;
  logic irq_seen_q;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_pop;
  logic reuse;
  logic [5:0] feed_last;
  aes_host_pkg::sfr_wr_t setup_wr;

  ////////////////////////////////////////////////////////////////////
  // Register write sequence for setup, indexed by step
  function automatic aes_host_pkg::sfr_wr_t host_write(input logic [5:0] step,
                                                      input aes_host_pkg::job_t j);
    aes_host_pkg::sfr_wr_t w;
    logic [15:0] base;
    logic [15:0] size;
    logic [5:0] idx;
    logic [1:0] ch;
    logic [5:0] k;
    idx = step - 6'h04;
    ch = 2'(idx / aes_host_pkg::CH_WRITES);
    k = idx % aes_host_pkg::CH_WRITES;
    // Vector area starts one block before the data area
    case (ch)
      2'h0: base = j.key_base;
      2'h1: base = j.data_base;
      2'h2: base = j.data_base - 16'h0010;
      default: base = j.out_base;
    endcase
    // Low nibble dropped: caller supplies a padded count
    size = (ch == 2'h0) ? {10'h000, aes_host_pkg::key_bytes(j.ksel)}
                        : {j.nbytes[15:4], 4'h0};
    w.addr = aes_host_pkg::ADDR_EN;
    w.data = aes_host_pkg::EN_OFF;
    case (step)
      6'h00: w.addr = aes_host_pkg::ADDR_EN;
      6'h01:
      begin
        w.addr = aes_host_pkg::ADDR_BCFG;
        w.data = aes_host_pkg::BCFG_RESET;
      end
      6'h02:
      begin
        w.addr = aes_host_pkg::ADDR_DCFG;
        w.data = aes_host_pkg::dcfg_word(j);
      end
      6'h03:
      begin
        w.addr = aes_host_pkg::ADDR_BCFG;
        w.data = aes_host_pkg::bcfg_word(j);
      end
      6'h28:
      begin
        w.addr = aes_host_pkg::ADDR_INT;
        w.data = aes_host_pkg::INT_CLEAR;
      end
      aes_host_pkg::DMA_LAST:
      begin
        w.addr = aes_host_pkg::ADDR_ACT;
        w.data = aes_host_pkg::ACT_START;
      end
      default:
      begin
        case (k)
          6'h00:
          begin
            w.addr = aes_host_pkg::ADDR_SEL;
            w.data = {6'h00, ch};
          end
          6'h01:
          begin
            w.addr = aes_host_pkg::ADDR_NCF;
            case (ch)
              2'h0: w.data = aes_host_pkg::NCF_KEY;
              2'h1: w.data = aes_host_pkg::NCF_DATA;
              2'h2: w.data = aes_host_pkg::NCF_CHAIN;
              default:
              begin
                w.data = aes_host_pkg::NCF_RESULT;
                w.data[aes_host_pkg::NCF_IRQ_BIT] = j.irq_en;
              end
            endcase
          end
          6'h02:
          begin
            w.addr = aes_host_pkg::ADDR_NMD;
            w.data = (ch == 2'h0) ? aes_host_pkg::NMD_WRAP : aes_host_pkg::NMD_NONE;
          end
          6'h03:
          begin
            w.addr = aes_host_pkg::ADDR_BAH;
            w.data = base[15:8];
          end
          6'h04:
          begin
            w.addr = aes_host_pkg::ADDR_BAL;
            w.data = base[7:0];
          end
          6'h05:
          begin
            w.addr = aes_host_pkg::ADDR_SZH;
            w.data = size[15:8];
          end
          6'h06:
          begin
            w.addr = aes_host_pkg::ADDR_SZL;
            w.data = size[7:0];
          end
          6'h07:
          begin
            w.addr = aes_host_pkg::ADDR_AOH;
            w.data = 8'h00;
          end
          default:
          begin
            w.addr = aes_host_pkg::ADDR_AOL;
            w.data = 8'h00;
          end
        endcase
      end
    endcase
    host_write = w;
  endfunction : host_write

  // Port for feed byte n: alternate data and key, then key only
  function automatic logic [7:0] feed_port(input logic [5:0] n);
    if (n < 6'h20)
      feed_port = n[0] ? aes_host_pkg::ADDR_KIN : aes_host_pkg::ADDR_BIN;
    else
      feed_port = aes_host_pkg::ADDR_KIN;
  endfunction : feed_port

  ////////////////////////////////////////////////////////////////////
  // Input byte buffer; stalls the user when the feed lags
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_in_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .wr_valid(in_valid),
    .wr_data(in_data),
    .wr_ready(in_ready),
    .rd_valid(fifo_valid),
    .rd_data(fifo_data),
    .rd_ready(fifo_pop)
  );

  assign fifo_pop = (state_q == ST_FEED);
  // Skip setup when the device already holds this configuration
  assign reuse = cfg_ok_q && !job_in.dma && (cfg_b_q == aes_host_pkg::bcfg_word(job_in))
                 && (cfg_d_q == aes_host_pkg::dcfg_word(job_in));
  assign feed_last = aes_host_pkg::key_bytes(job_q.ksel) + 6'h0f;
  assign setup_wr = host_write(step_q, job_q);

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      step_q <= 6'h00;
      job_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (job_valid && job_ready)
          begin
            job_q <= job_in;
            if (job_in.dma)
            begin
              state_q <= ST_DMA_WR;
              step_q <= 6'h00;
            end
            else if (reuse)
            begin
              state_q <= ST_FEED;
              step_q <= 6'h00;
            end
            else
            begin
              state_q <= ST_CFG;
              step_q <= 6'h01;
            end
          end
        ST_CFG:
          if (step_q == 6'h03)
          begin
            state_q <= ST_FEED;
            step_q <= 6'h00;
          end
          else
            step_q <= step_q + 6'h01;
        ST_FEED:
          if (fifo_valid)
          begin
            step_q <= step_q + 6'h01;
            if (step_q == feed_last)
              state_q <= ST_POLL_RD;
          end
        ST_POLL_RD: state_q <= ST_POLL_WT;
        ST_POLL_WT:
          // Either the done bit or a latched interrupt ends the wait
          if (sfr_rdata[aes_host_pkg::BCFG_DONE_BIT] || irq_seen_q)
          begin
            state_q <= ST_RES_RD;
            step_q <= 6'h00;
          end
          else
            state_q <= ST_POLL_RD;
        ST_RES_RD: state_q <= ST_RES_WT;
        ST_RES_WT: state_q <= ST_RES_OUT;
        ST_RES_OUT:
          if (res_ready)
          begin
            step_q <= step_q + 6'h01;
            state_q <= (step_q[3:0] == aes_host_pkg::RES_LAST) ? ST_DONE : ST_RES_RD;
          end
        ST_DMA_WR:
          if (step_q == aes_host_pkg::DMA_LAST)
            state_q <= ST_DMA_RD;
          else
            step_q <= step_q + 6'h01;
        ST_DMA_RD: state_q <= ST_DMA_WT;
        ST_DMA_WT:
          if ((sfr_rdata & aes_host_pkg::ACT_MASK) == 8'h00)
            state_q <= ST_DONE;
          else
            state_q <= ST_DMA_RD;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Register port strobes, one cycle each
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sfr_req <= '0;
    else
    begin
      sfr_req.wr <= 1'b0;
      sfr_req.rd <= 1'b0;
      case (state_q)
        ST_CFG, ST_DMA_WR:
        begin
          sfr_req.wr <= 1'b1;
          sfr_req.addr <= setup_wr.addr;
          sfr_req.wdata <= setup_wr.data;
        end
        ST_FEED:
          if (fifo_valid)
          begin
            sfr_req.wr <= 1'b1;
            sfr_req.addr <= feed_port(step_q);
            sfr_req.wdata <= fifo_data;
          end
        ST_POLL_RD:
        begin
          sfr_req.rd <= 1'b1;
          sfr_req.addr <= aes_host_pkg::ADDR_BCFG;
        end
        ST_RES_RD:
        begin
          sfr_req.rd <= 1'b1;
          sfr_req.addr <= aes_host_pkg::ADDR_YOUT;
        end
        ST_DMA_RD:
        begin
          sfr_req.rd <= 1'b1;
          sfr_req.addr <= aes_host_pkg::ADDR_ACT;
        end
        default: sfr_req.wr <= 1'b0;
      endcase
    end
  end

  // Configuration shadow and done-interrupt latch; set beats clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_ok_q <= 1'b0;
      cfg_b_q <= 8'h00;
      cfg_d_q <= 8'h00;
      irq_seen_q <= 1'b0;
    end
    else
    begin
      if (state_q == ST_CFG || state_q == ST_DMA_WR)
      begin
        cfg_ok_q <= 1'b1;
        cfg_b_q <= aes_host_pkg::bcfg_word(job_q);
        cfg_d_q <= aes_host_pkg::dcfg_word(job_q);
      end
      if (cipher_done_irq)
        irq_seen_q <= 1'b1;
      else if (state_q == ST_IDLE)
        irq_seen_q <= 1'b0;
    end
  end

  // Result handshake and user status
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      res_valid <= 1'b0;
      res_data <= 8'h00;
      job_ready <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= (state_q == ST_DONE);
      if (state_q == ST_RES_WT)
      begin
        res_valid <= 1'b1;
        res_data <= sfr_rdata;
      end
      else if (state_q == ST_RES_OUT && res_ready)
        res_valid <= 1'b0;
      if (state_q == ST_IDLE && job_valid && job_ready)
      begin
        job_ready <= 1'b0;
        busy <= 1'b1;
      end
      else if (state_q == ST_DONE)
      begin
        job_ready <= 1'b1;
        busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checking helpers
  logic [7:0] last_wr_q;
  logic [1:0] last_sel_q;
  logic [5:0] bin_cnt_q;
  logic [5:0] kin_cnt_q;
  logic [4:0] res_cnt_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_wr_q <= 8'h00;
      last_sel_q <= 2'h0;
      bin_cnt_q <= 6'h00;
      kin_cnt_q <= 6'h00;
      res_cnt_q <= 5'h00;
    end
    else if (state_q == ST_IDLE)
    begin
      bin_cnt_q <= 6'h00;
      kin_cnt_q <= 6'h00;
      res_cnt_q <= 5'h00;
    end
    else
    begin
      if (sfr_req.wr)
        last_wr_q <= sfr_req.addr;
      if (sfr_req.wr && sfr_req.addr == aes_host_pkg::ADDR_SEL)
        last_sel_q <= sfr_req.wdata[1:0];
      if (sfr_req.wr && sfr_req.addr == aes_host_pkg::ADDR_BIN)
        bin_cnt_q <= bin_cnt_q + 6'h01;
      if (sfr_req.wr && sfr_req.addr == aes_host_pkg::ADDR_KIN)
        kin_cnt_q <= kin_cnt_q + 6'h01;
      if (res_valid && res_ready)
        res_cnt_q <= res_cnt_q + 5'h01;
    end
  end

  AST_RESET_FIRST: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_CFG && $past(state_q) == ST_IDLE) |=> (sfr_req.wr
      && sfr_req.addr == aes_host_pkg::ADDR_BCFG && sfr_req.wdata == 8'h00))
    else $error("setup did not start with a zero block config write");

  AST_PLAIN_PATH: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_req.wr && sfr_req.addr == aes_host_pkg::ADDR_DCFG && !(job_q.dma && job_q.cbc))
      |-> sfr_req.wdata == 8'h00)
    else $error("plain path got a nonzero dataflow config");

  AST_ALTERNATE: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_req.wr && sfr_req.addr == aes_host_pkg::ADDR_BIN)
      |-> (last_wr_q != aes_host_pkg::ADDR_BIN && kin_cnt_q == bin_cnt_q))
    else $error("data byte not alternated with key byte");

  AST_KEY_TOTAL: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(state_q == ST_POLL_RD) && !job_q.dma |=> (bin_cnt_q == 6'h10
      && kin_cnt_q == aes_host_pkg::key_bytes(job_q.ksel)))
    else $error("wrong count of data or key bytes before waiting");

  AST_RESULTS: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_DONE && !job_q.dma) |-> res_cnt_q == 5'h10)
    else $error("block ended without sixteen result bytes");

  AST_CH_OFF: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_req.wr && sfr_req.addr == aes_host_pkg::ADDR_EN) |-> sfr_req.wdata[3:0] == 4'h0)
    else $error("cipher channels not disabled");

  AST_SEL_CODE: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_req.wr && sfr_req.addr == aes_host_pkg::ADDR_SEL) |-> ##1 (sfr_req.wr
      && sfr_req.addr == aes_host_pkg::ADDR_NCF
      && sfr_req.wdata[3:0] == 4'(4'h5 + {2'h0, last_sel_q})))
    else $error("channel code does not follow channel select");

  AST_WRAP: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_req.wr && sfr_req.addr == aes_host_pkg::ADDR_NMD)
      |-> sfr_req.wdata == ((last_sel_q == 2'h0) ? 8'h01 : 8'h00))
    else $error("wrap mode wrong for channel");

  AST_SIZE16: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_req.wr && sfr_req.addr == aes_host_pkg::ADDR_SZL && last_sel_q != 2'h0)
      |-> sfr_req.wdata[3:0] == 4'h0)
    else $error("data size not a multiple of sixteen");

  AST_OFFSET_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_req.wr && (sfr_req.addr == aes_host_pkg::ADDR_AOH
      || sfr_req.addr == aes_host_pkg::ADDR_AOL)) |-> sfr_req.wdata == 8'h00)
    else $error("address offset not cleared");

  AST_START_POLL: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_req.wr && sfr_req.addr == aes_host_pkg::ADDR_ACT) |-> sfr_req.wdata == 8'h0f
      ##1 (sfr_req.rd && sfr_req.addr == aes_host_pkg::ADDR_ACT))
    else $error("channel start not followed by activity poll");
endmodule : aes_host_ctrl

/* File: inc/aes_host_pkg.sv */
// Constants and carrier types for the cipher host controller
package aes_host_pkg;
  // Device register addresses
  localparam logic [7:0] ADDR_BCFG = 8'he9;
  localparam logic [7:0] ADDR_DCFG = 8'hea;
  localparam logic [7:0] ADDR_BIN = 8'heb;
  localparam logic [7:0] ADDR_KIN = 8'hec;
  localparam logic [7:0] ADDR_XIN = 8'hed;
  localparam logic [7:0] ADDR_YOUT = 8'hee;
  localparam logic [7:0] ADDR_SEL = 8'hd1;
  localparam logic [7:0] ADDR_NCF = 8'hc9;
  localparam logic [7:0] ADDR_NMD = 8'hca;
  localparam logic [7:0] ADDR_BAH = 8'hcb;
  localparam logic [7:0] ADDR_BAL = 8'hcc;
  localparam logic [7:0] ADDR_SZH = 8'hcd;
  localparam logic [7:0] ADDR_SZL = 8'hce;
  localparam logic [7:0] ADDR_AOH = 8'hcf;
  localparam logic [7:0] ADDR_AOL = 8'hd2;
  localparam logic [7:0] ADDR_EN = 8'hd3;
  localparam logic [7:0] ADDR_INT = 8'hd4;
  localparam logic [7:0] ADDR_ACT = 8'hd5;
  // Field positions and values
  localparam int BCFG_KS_LSB = 0;
  localparam int BCFG_DEC_BIT = 2;
  localparam int BCFG_EN_BIT = 3;
  localparam int BCFG_DONE_BIT = 5;
  localparam int NCF_IRQ_BIT = 7;
  localparam logic [7:0] BCFG_RESET = 8'h00;
  localparam logic [7:0] DCFG_BASIC = 8'h00;
  localparam logic [7:0] DCFG_CBC = 8'h01;
  localparam logic [7:0] NCF_KEY = 8'h05;
  localparam logic [7:0] NCF_DATA = 8'h06;
  localparam logic [7:0] NCF_CHAIN = 8'h07;
  localparam logic [7:0] NCF_RESULT = 8'h08;
  localparam logic [7:0] NMD_WRAP = 8'h01;
  localparam logic [7:0] NMD_NONE = 8'h00;
  localparam logic [7:0] EN_OFF = 8'h00;
  localparam logic [7:0] INT_CLEAR = 8'h00;
  localparam logic [7:0] ACT_START = 8'h0f;
  localparam logic [7:0] ACT_MASK = 8'h0f;
  localparam logic [1:0] KS_128 = 2'h0;
  localparam logic [1:0] KS_192 = 2'h1;
  localparam logic [1:0] KS_256 = 2'h2;
  // Counts
  localparam logic [5:0] BLOCK_BYTES = 6'h10;
  localparam logic [5:0] CH_WRITES = 6'h09;
  localparam logic [5:0] DMA_LAST = 6'h29;
  localparam logic [3:0] RES_LAST = 4'hf;

  typedef struct packed {
    logic dma;
    logic dec;
    logic cbc;
    logic irq_en;
    logic [1:0] ksel;
    logic [15:0] key_base;
    logic [15:0] data_base;
    logic [15:0] out_base;
    logic [15:0] nbytes;
  } job_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } sfr_wr_t;

  // Key length in bytes
  function automatic logic [5:0] key_bytes(input logic [1:0] ks);
    case (ks)
      KS_192: key_bytes = 6'h18;
      KS_256: key_bytes = 6'h20;
      default: key_bytes = 6'h10;
    endcase
  endfunction : key_bytes

  // Block config word: enable, direction, key size
  function automatic logic [7:0] bcfg_word(input job_t j);
    bcfg_word = BCFG_RESET;
    bcfg_word[BCFG_KS_LSB +: 2] = j.ksel;
    bcfg_word[BCFG_DEC_BIT] = j.dec;
    bcfg_word[BCFG_EN_BIT] = 1'b1;
  endfunction : bcfg_word

  // Chaining only exists on the channel-fed path
  function automatic logic [7:0] dcfg_word(input job_t j);
    dcfg_word = (j.dma && j.cbc) ? DCFG_CBC : DCFG_BASIC;
  endfunction : dcfg_word
endpackage : aes_host_pkg

/* File: hw/byte_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fill side
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  // Drain side
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input wire logic rd_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("byte_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  assign rd_valid = (cnt_q != '0);
  assign rd_data = mem[rp_q];

  // Storage has no reset; only pointers, fill level and ready need defined state
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_q] <= wr_data;
  end

  // Pointers, fill level and registered ready
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      wr_ready <= 1'b1;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      case ({push, pop})
        2'b10:
        begin
          cnt_q <= cnt_q + 1'b1;
          wr_ready <= (cnt_q < (AW+1)'(DEPTH - 1));
        end
        2'b01:
        begin
          cnt_q <= cnt_q - 1'b1;
          wr_ready <= 1'b1;
        end
        default:
          wr_ready <= (cnt_q < (AW+1)'(DEPTH));
      endcase
    end
  end
endmodule : byte_fifo

/* File: tb/aes_dev_model.sv */
// Behavioural cipher device seen through its register port
`timescale 1ns/100ps
module aes_dev_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire aes_host_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic cipher_done_irq
);
  logic [7:0] bcfg_q, dcfg_q, act_q, sel_q, bal2_q, rlast_q;
  logic [7:0] ncf_q [4];
  logic [7:0] nmd_q [4];
  logic [7:0] dat_q [16];
  logic [7:0] key_q [16];
  logic [5:0] nd_q, nk_q;
  logic [4:0] no_q;
  logic [3:0] act_cnt_q;
  logic [5:0] klen;
  //////////////////////////////////////////////////////////////////////
  // Key length from the size field
  assign klen = 6'h10 + {1'b0, bcfg_q[1:0], 3'h0};
  // Read data stands while rd is high; a released bus shows the inverse of the last read
  always_comb
  begin
    sfr_rdata = ~rlast_q;
    if (sfr_req.rd)
      case (sfr_req.addr)
        aes_host_pkg::ADDR_BCFG: sfr_rdata = bcfg_q;
        aes_host_pkg::ADDR_ACT: sfr_rdata = {1'b0, act_q[6:0]};
        aes_host_pkg::ADDR_YOUT: sfr_rdata = dat_q[no_q[3:0]] ^ key_q[no_q[3:0]];
        default: sfr_rdata = ~rlast_q;
      endcase
  end
  // Writes; xor stands in for the cipher so results stay checkable
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {bcfg_q, dcfg_q, act_q, sel_q, bal2_q, nd_q, nk_q, no_q, act_cnt_q} <= '0;
      cipher_done_irq <= 1'b0;
      rlast_q <= 8'h00;
    end
    else
    begin
      cipher_done_irq <= 1'b0;
      if (act_cnt_q == 4'h1)
        act_q <= 8'h00;
      if (act_cnt_q != 4'h0)
        act_cnt_q <= act_cnt_q - 4'h1;
      if (nd_q == 6'h10 && nk_q == klen && !bcfg_q[5] && bcfg_q[3])
      begin
        bcfg_q[5] <= 1'b1;
        cipher_done_irq <= 1'b1;
      end
      if (sfr_req.wr)
        case (sfr_req.addr)
          aes_host_pkg::ADDR_BCFG:
          begin
            bcfg_q <= sfr_req.wdata;
            {nd_q, nk_q, no_q} <= '0;
          end
          aes_host_pkg::ADDR_DCFG: dcfg_q <= sfr_req.wdata;
          aes_host_pkg::ADDR_BIN:
          begin
            dat_q[nd_q[3:0]] <= sfr_req.wdata;
            nd_q <= nd_q + 6'h1;
          end
          aes_host_pkg::ADDR_KIN:
          begin
            if (nk_q < 6'h10)
              key_q[nk_q[3:0]] <= sfr_req.wdata;
            nk_q <= nk_q + 6'h1;
          end
          aes_host_pkg::ADDR_SEL: sel_q <= sfr_req.wdata;
          aes_host_pkg::ADDR_NCF: ncf_q[sel_q[1:0]] <= sfr_req.wdata;
          aes_host_pkg::ADDR_NMD: nmd_q[sel_q[1:0]] <= sfr_req.wdata;
          aes_host_pkg::ADDR_BAL: if (sel_q == 8'h02) bal2_q <= sfr_req.wdata;
          aes_host_pkg::ADDR_ACT:
          begin
            act_q <= act_q | {1'b0, sfr_req.wdata[6:0]};
            act_cnt_q <= 4'hc;
          end
          default: ;
        endcase
      if (sfr_req.rd)
        rlast_q <= sfr_rdata;
      if (sfr_req.rd)
        case (sfr_req.addr)
          aes_host_pkg::ADDR_YOUT:
          begin
            no_q <= no_q + 5'h1;
            if (no_q == 5'hf)
            begin
              {nd_q, nk_q, no_q} <= '0;
              bcfg_q[5] <= 1'b0;
            end
          end
          default: ;
        endcase
    end
  end
endmodule : aes_dev_model

/* File: tb/test_aes_host_ctrl.sv */
// Self-checking bench for the cipher host controller
`timescale 1ns/100ps
module test_aes_host_ctrl;
  logic clk = 1'b0, reset_n = 1'b0, job_valid = 1'b0, in_valid = 1'b0;
  logic res_ready = 1'b1, job_ready, in_ready, res_valid, busy, done, irq;
  logic [7:0] in_data = 8'h00, res_data, rdata;
  aes_host_pkg::job_t job_in = '0;
  aes_host_pkg::sfr_req_t sfr_req;
  int error_cnt = 0, comparisons = 0;
  //////////////////////////////////////////////////////////////////////
  // Clock and design under test with its device
  always #50 clk = ~clk;
  aes_host_ctrl i_aes_host_ctrl (.clk(clk), .reset_n(reset_n), .job_valid(job_valid),
    .job_in(job_in), .job_ready(job_ready), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready),
    .busy(busy), .done(done), .sfr_req(sfr_req), .sfr_rdata(rdata), .cipher_done_irq(irq));
  aes_dev_model i_aes_dev_model (.clk(clk), .reset_n(reset_n), .sfr_req(sfr_req),
    .sfr_rdata(rdata), .cipher_done_irq(irq));
  //////////////////////////////////////////////////////////////////////
  task cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask : cmp
  task final_report;
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // Feeds data/key pairs then padding key bytes
  task feed(input logic [1:0] ks);
    for (int i = 0; i < 32 + 8 * ks; i++)
    begin
      @(negedge clk);
      in_valid = 1'b1;
      in_data = (i >= 32) ? 8'h77 : i[0] ? {i[4:1], 4'h5} : {3'h0, i[5:1]};
      @(posedge clk);
      while (in_ready !== 1'b1)
        @(posedge clk);
    end
    @(negedge clk);
    in_valid = 1'b0;
  endtask : feed
  task collect;
    for (int j = 0; j < 16; j++)
    begin
      @(posedge clk);
      while (res_valid !== 1'b1)
        @(posedge clk);
      cmp("result", {4'h0, j[3:0]} ^ {j[3:0], 4'h5}, res_data);
    end
  endtask : collect
  task run_job(input aes_host_pkg::job_t j);
    @(negedge clk);
    job_in = j;
    job_valid = 1'b1;
    @(negedge clk);
    job_valid = 1'b0;
    cmp("busy", 8'h01, {7'h0, busy});
    if (!j.dma)
      fork
        feed(j.ksel);
        collect();
      join
    while (done !== 1'b1)
      @(posedge clk);
  endtask : run_job
  // Register fed block with given size and direction
  task sfr_block(input logic [1:0] ks, input logic dec);
    run_job({1'b0, dec, 1'b0, 1'b0, ks, 64'h0});
    cmp("cfg", {4'h1, dec, ks[1:0]}, {4'h0, i_aes_dev_model.bcfg_q[3:0]});
  endtask : sfr_block
  // Channel fed chained job: per-channel codes and vector placement
  task dma_block;
    run_job({4'b1011, aes_host_pkg::KS_256, 48'h0100_0240_0300, 16'h0020});
    cmp("ncf0", 8'h05, i_aes_dev_model.ncf_q[0]);
    cmp("ncf1", 8'h06, i_aes_dev_model.ncf_q[1]);
    cmp("ncf2", 8'h07, i_aes_dev_model.ncf_q[2]);
    cmp("ncf3", 8'h88, i_aes_dev_model.ncf_q[3]);
    cmp("nmd0", 8'h01, i_aes_dev_model.nmd_q[0]);
    cmp("nmd2", 8'h00, i_aes_dev_model.nmd_q[2]);
    cmp("vector", 8'h30, i_aes_dev_model.bal2_q);
    cmp("dcfg", 8'h01, i_aes_dev_model.dcfg_q);
    cmp("act", 8'h00, i_aes_dev_model.act_q);
  endtask : dma_block
  //////////////////////////////////////////////////////////////////////
  // Watchdog: far beyond the few hundred cycles the run needs
  initial
  begin
    #2ms;
    error_cnt++;
    final_report();
  end
  initial
  begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    cmp("idle", 8'h06, {5'h0, job_ready, in_ready, busy});
    sfr_block(aes_host_pkg::KS_128, 1'b0);
    sfr_block(aes_host_pkg::KS_128, 1'b0);
    sfr_block(aes_host_pkg::KS_192, 1'b1);
    sfr_block(aes_host_pkg::KS_256, 1'b1);
    dma_block();
    final_report();
  end
endmodule : test_aes_host_ctrl
